/* File: bench/tb.sv */
// Purpose: self-checking bench for the rx/tx configuration bank
// Assumes: zero wait apb slave, outputs follow one edge after the write edge
// Notes:   random upper data bits and strobes from a fixed seed
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_b, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [3:0]  pstrb;
   logic        pready, pslverr, err;
   logic [31:0] prdata;
   logic [6:0]  corner;
   logic        ropen, capsh, lowp, demod_en, ina2, shortc, restore, drvrst, dac_en, dac_zero;
   logic [2:0]  extres;
   logic [1:0]  pga;
   logic [3:0]  strength, bw;
   logic [7:0]  last_rx;
   int          n_errors = 0;
   int          check_count = 0;
   int          seed = 32'h1280;
   wire  [16:0] rx_out = {corner, ropen, capsh, extres, lowp, demod_en, ina2, pga};
   wire  [12:0] tx_out = {shortc, restore, drvrst, dac_en, dac_zero, strength, bw};
   bzc_config_regs bzc_config_regs_i (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .hpf_corner_onehot(corner), .hpf_resistor_open(ropen),
      .hpf_int_caps_shorted(capsh), .hpf_ext_res_select(extres), .input_amp_low_power(lowp),
      .demod_clock_enable(demod_en), .ina_gain_two(ina2), .pga_gain_select(pga),
      .coupling_cap_short_close(shortc), .dc_restore_close(restore), .drive_amp_reset_close(drvrst),
      .synth_dac_enable(dac_en), .synth_dac_force_zero(dac_zero), .drive_amp_strength(strength),
      .drive_amp_bandwidth(bw));
   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [16:0] exp_rx(input logic [7:0] v);
      logic [3:0] h;
      h = v[7:4];
      return {(h <= 4'h6) ? 7'(7'h01 << h) : 7'h00, (h == 4'h7) || (h == 4'hf), h >= 4'h7,
              (h >= 4'h8 && h <= 4'he) ? 3'(h - 4'h8) : 3'h0, v[3], ~v[2], v[1:0] != 2'h0,
              (v[1:0] == 2'h0) ? 2'h0 : 2'(v[1:0] - 2'h1)};
   endfunction : exp_rx
   function automatic logic [12:0] exp_tx(input logic [7:0] v);
      return {~v[7], v[6], v[5], ~v[5], v[4], 4'(4'h1 << v[3:2]), 4'(4'h1 << v[1:0])};
   endfunction : exp_tx
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // setup cycle, then access held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      // pready and data are read at the edge itself, before the design updates them
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         n_errors++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // write, check outputs one edge later, then read back
   task automatic wr_chk(input logic [11:0] a, input logic [7:0] v, input logic [7:0] old);
      logic [7:0] e;
      e = (a == bzc_pkg::RX_CFG_ADDR) ? v : v;
      apb(1'b1, a, {24'($random(seed)), v}, 4'h1 | 4'($random(seed)));
      @(posedge mclk);
      #1;
      if (a == bzc_pkg::RX_CFG_ADDR) chk("rx outputs", 32'(exp_rx(e)), 32'(rx_out));
      else chk("tx outputs", 32'(exp_tx(e)), 32'(tx_out));
      apb(1'b0, a, 32'h0, 4'h0);
      chk("readback", {24'h0, e}, rd);
      chk("pslverr", 32'h0, 32'(err));
   endtask : wr_chk
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      chk("rx reset outputs", 32'(exp_rx(8'h00)), 32'(rx_out));
      chk("tx reset outputs", 32'(exp_tx(8'h80)), 32'(tx_out));
      apb(1'b0, bzc_pkg::RX_CFG_ADDR, 32'h0, 4'h0);
      chk("rx reset value", 32'h00, rd);
      apb(1'b0, bzc_pkg::TX_CFG_ADDR, 32'h0, 4'h0);
      chk("tx reset value", 32'h80, rd);
      $display("test reset done");
      for (int i = 0; i < 16; i++)
      begin
         last_rx = {4'(i), 2'($random(seed)), 2'(i)};
         wr_chk(bzc_pkg::RX_CFG_ADDR, last_rx, 8'h0);
      end
      $display("test rx codes done");
      wr_chk(bzc_pkg::TX_CFG_ADDR, 8'h00, 8'h0);
      wr_chk(bzc_pkg::TX_CFG_ADDR, 8'hff, 8'h0);
      for (int i = 0; i < 16; i++)
         wr_chk(bzc_pkg::TX_CFG_ADDR, {4'($random(seed)), 4'(i)}, 8'h0);
      wr_chk(bzc_pkg::TX_CFG_ADDR, 8'hc0, 8'h0);
      wr_chk(bzc_pkg::TX_CFG_ADDR, 8'hff, 8'h0);
      $display("test tx codes done");
      apb(1'b1, bzc_pkg::TX_CFG_ADDR, 32'h0000_0033, 4'he);
      apb(1'b0, bzc_pkg::TX_CFG_ADDR, 32'h0, 4'h0);
      chk("strobe ignored", 32'h0000_00ff, rd);
      apb(1'b1, 12'h098, 32'h0000_0055, 4'hf);
      chk("unmapped write error", 32'h1, 32'(err));
      apb(1'b0, 12'h098, 32'h0, 4'h0);
      chk("unmapped read", 32'h0, rd);
      apb(1'b0, bzc_pkg::RX_CFG_ADDR, 32'h0, 4'h0);
      chk("rx untouched", {24'h0, last_rx}, rd);
      $display("test refusals done");
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      chk("tx mid-run reset outputs", 32'(exp_tx(8'h80)), 32'(tx_out));
      apb(1'b0, bzc_pkg::TX_CFG_ADDR, 32'h0, 4'h0);
      chk("tx mid-run reset value", 32'h80, rd);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule : tb

/* File: rtl/bzc_config_regs.sv */
// Purpose: apb register bank driving rx/tx analog control lines
// Assumes: single clock mclk at 100 MHz, synchronous active-low reset
// Notes:   zero wait state slave; unmapped addresses read zero, pslverr set
//
// Behaviour
// - rx config at index 0x24: hpf 7:4, amp mode 3, demod 2, gain 1:0.
// - hpf codes 0x0..0x6 select rising corners 100Hz..10kHz.
// - codes 0x7/0xf bypass; 0x8..0xe external-cap resistor, caps shorted.
// - amp mode 0 is high-power low-noise, 1 is low power.
// - demod disable 1 gates off the demodulation clock.
// - gain select decodes totals 1, 2, 5, 10 with amp/pga split.
// - tx config at index 0x25; ext cap resets to 1, others zero.
// - ext cap 0 closes the coupling-pin short switch; 1 opens it.
// - dc restore 1 closes the feedback restore switch.
// - drive reset disables dac and closes drive amp reset switch.
// - dac reset forces the synthesis dac output to zero.
// - strength and bandwidth each decode low..high in four steps.
//
// Decided for this implementation: register access over APB.
module bzc_config_regs
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   output logic      [6:0]  hpf_corner_onehot,
   output logic             hpf_resistor_open,
   output logic             hpf_int_caps_shorted,
   output logic      [2:0]  hpf_ext_res_select,
   output logic             input_amp_low_power,
   output logic             demod_clock_enable,
   output logic             ina_gain_two,
   output logic      [1:0]  pga_gain_select,
   output logic             coupling_cap_short_close,
   output logic             dc_restore_close,
   output logic             drive_amp_reset_close,
   output logic             synth_dac_enable,
   output logic             synth_dac_force_zero,
   output logic      [3:0]  drive_amp_strength,
   output logic      [3:0]  drive_amp_bandwidth
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic [7:0] rx_cfg_reg;
   logic [7:0] tx_cfg_reg;
   logic [7:0] rx_cfg_next;
   logic [7:0] tx_cfg_next;
   wire        access_phase = psel & penable;
   wire        hit_rx       = (paddr == bzc_pkg::RX_CFG_ADDR);
   wire        hit_tx       = (paddr == bzc_pkg::TX_CFG_ADDR);
   wire        hit_any      = hit_rx | hit_tx;
   wire        wr_rx        = access_phase & pwrite & hit_rx & pstrb[0];
   wire        wr_tx        = access_phase & pwrite & hit_tx & pstrb[0];
   wire [7:0]  rd_byte      = hit_rx ? rx_cfg_reg : (hit_tx ? tx_cfg_reg : 8'h00);

   assign rx_cfg_next = wr_rx ? pwdata[7:0] : rx_cfg_reg;
   assign tx_cfg_next = wr_tx ? pwdata[7:0] : tx_cfg_reg;

   // ----------------------------------------
   // field extraction
   // ----------------------------------------
   wire [3:0] hpf_code  = rx_cfg_reg[bzc_pkg::HPF_LSB +: 4];
   wire [1:0] gain_code = rx_cfg_reg[bzc_pkg::GAIN_LSB +: 2];
   wire       hpf_byp   = (hpf_code == bzc_pkg::HPF_BYPASS_A) | (hpf_code == bzc_pkg::HPF_BYPASS_B);
   wire       hpf_int   = (hpf_code <= bzc_pkg::HPF_LAST_CORNER);
   wire       drv_rst   = tx_cfg_reg[bzc_pkg::DRVRST_BIT];
   wire       dac_rst   = tx_cfg_reg[bzc_pkg::DACRST_BIT];
   wire [6:0] corner_dec;
   wire [3:0] strength_dec;
   wire [3:0] bw_dec;

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++)
      begin : g_corner
         assign corner_dec[gi] = (hpf_code == 4'(gi));
      end
      for (gi = 0; gi < 4; gi++)
      begin : g_drive
         assign strength_dec[gi] = (tx_cfg_reg[bzc_pkg::STRENGTH_LSB +: 2] == 2'(gi));
         assign bw_dec[gi]       = (tx_cfg_reg[bzc_pkg::BW_LSB +: 2] == 2'(gi));
      end
   endgenerate

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rx_cfg_reg <= bzc_pkg::RX_CFG_RESET;
         tx_cfg_reg <= bzc_pkg::TX_CFG_RESET;
      end
      else
      begin
         rx_cfg_reg <= rx_cfg_next;
         tx_cfg_reg <= tx_cfg_next;
      end
   end

   // read data is registered in the setup phase so it is valid in access
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // analog control outputs
   // ----------------------------------------
   // outputs sample current register state, so they follow a write by one
   // further edge; the analog side never sees a half-written field
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         hpf_corner_onehot        <= 7'h01;
         hpf_resistor_open        <= 1'b0;
         hpf_int_caps_shorted     <= 1'b0;
         hpf_ext_res_select       <= 3'h0;
         input_amp_low_power      <= 1'b0;
         demod_clock_enable       <= 1'b1;
         ina_gain_two             <= 1'b0;
         pga_gain_select          <= 2'h0;
         coupling_cap_short_close <= 1'b0;
         dc_restore_close         <= 1'b0;
         drive_amp_reset_close    <= 1'b0;
         synth_dac_enable         <= 1'b1;
         synth_dac_force_zero     <= 1'b0;
         drive_amp_strength       <= 4'h1;
         drive_amp_bandwidth      <= 4'h1;
      end
      else
      begin
         hpf_corner_onehot        <= corner_dec;
         hpf_resistor_open        <= hpf_byp;
         hpf_int_caps_shorted     <= ~hpf_int;
         hpf_ext_res_select       <= (~hpf_int & ~hpf_byp) ? 3'(hpf_code - 4'h8) : 3'h0;
         input_amp_low_power      <= rx_cfg_reg[bzc_pkg::AMP_MODE_BIT];
         demod_clock_enable       <= ~rx_cfg_reg[bzc_pkg::DEMOD_BIT];
         ina_gain_two             <= (gain_code != 2'h0);
         pga_gain_select          <= (gain_code == 2'h0) ? 2'h0 : 2'(gain_code - 2'h1);
         coupling_cap_short_close <= ~tx_cfg_reg[bzc_pkg::EXTCAP_BIT];
         dc_restore_close         <= tx_cfg_reg[bzc_pkg::RESTORE_BIT];
         drive_amp_reset_close    <= drv_rst;
         synth_dac_enable         <= ~drv_rst;
         synth_dac_force_zero     <= dac_rst;
         drive_amp_strength       <= strength_dec;
         drive_amp_bandwidth      <= bw_dec;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // register stores and refusals, checked at the edge after the access
   a_rx_write_store: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_rx
      |=> rx_cfg_reg == $past(pwdata[7:0]))
      else $error("rx write lost");
   a_tx_write_store: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_tx
      |=> tx_cfg_reg == $past(pwdata[7:0]))
      else $error("tx write lost");
   a_strobe_block: assert property (@(posedge mclk) disable iff (!rst_b)
      (access_phase && pwrite && !pstrb[0])
      |=> $stable(rx_cfg_reg) && $stable(tx_cfg_reg))
      else $error("write without strobe stored");
   a_unmapped_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (access_phase && pwrite && !hit_any)
      |=> $stable(rx_cfg_reg) && $stable(tx_cfg_reg))
      else $error("unmapped write stored");
   a_read_stable: assert property (@(posedge mclk) disable iff (!rst_b)
      (access_phase && !pwrite)
      |=> $stable(rx_cfg_reg) && $stable(tx_cfg_reg))
      else $error("read changed state");
   // bus answer: one access cycle, error only on unmapped addresses
   a_pready_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
      (psel && !penable)
      |=> pready)
      else $error("pready missing in access");
   a_pready_idle: assert property (@(posedge mclk) disable iff (!rst_b)
      !(psel && !penable)
      |=> !pready)
      else $error("pready outside access");
   a_unmapped_err: assert property (@(posedge mclk) disable iff (!rst_b)
      (psel && !penable && !hit_any)
      |=> pslverr)
      else $error("unmapped error missing");
   a_mapped_ok: assert property (@(posedge mclk) disable iff (!rst_b)
      (psel && !penable && hit_any)
      |=> !pslverr)
      else $error("mapped access flagged");
   a_read_rx: assert property (@(posedge mclk) disable iff (!rst_b)
      (psel && !penable && !pwrite && hit_rx)
      |=> prdata == {24'h000000, $past(rx_cfg_reg)})
      else $error("rx read data wrong");
   a_read_tx: assert property (@(posedge mclk) disable iff (!rst_b)
      (psel && !penable && !pwrite && hit_tx)
      |=> prdata == {24'h000000, $past(tx_cfg_reg)})
      else $error("tx read data wrong");
   // receive decodes
   a_hpf_corner: assert property (@(posedge mclk) disable iff (!rst_b)
      (hpf_code <= 4'h6)
      |=> $onehot(hpf_corner_onehot) && !hpf_int_caps_shorted)
      else $error("hpf corner decode wrong");
   a_corner_index: assert property (@(posedge mclk) disable iff (!rst_b)
      (hpf_code <= 4'h6)
      |=> hpf_corner_onehot == 7'(7'h01 << $past(hpf_code)) && !hpf_resistor_open)
      else $error("hpf corner index wrong");
   a_hpf_bypass: assert property (@(posedge mclk) disable iff (!rst_b)
      (hpf_code == 4'hf || hpf_code == 4'h7)
      |=> hpf_resistor_open && hpf_int_caps_shorted)
      else $error("hpf bypass wrong");
   a_hpf_ext_res: assert property (@(posedge mclk) disable iff (!rst_b)
      (hpf_code >= 4'h8 && hpf_code <= 4'he)
      |=> hpf_int_caps_shorted && !hpf_resistor_open && hpf_corner_onehot == 7'h00)
      else $error("hpf external mode wrong");
   a_hpf_res_index: assert property (@(posedge mclk) disable iff (!rst_b)
      (hpf_code >= 4'h8 && hpf_code <= 4'he)
      |=> hpf_ext_res_select == 3'($past(hpf_code) - 4'h8))
      else $error("hpf resistor index wrong");
   a_amp_mode: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_rx
      |=> ##1 input_amp_low_power == $past(pwdata[3], 2))
      else $error("amp mode wrong");
   a_demod_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      rx_cfg_reg[2]
      |=> !demod_clock_enable)
      else $error("demod clock not gated");
   a_demod_on: assert property (@(posedge mclk) disable iff (!rst_b)
      !rx_cfg_reg[2]
      |=> demod_clock_enable)
      else $error("demod clock gated");
   a_gain_one: assert property (@(posedge mclk) disable iff (!rst_b)
      gain_code == 2'h0
      |=> !ina_gain_two && pga_gain_select == 2'h0)
      else $error("gain one wrong");
   a_gain_two: assert property (@(posedge mclk) disable iff (!rst_b)
      gain_code == 2'h1
      |=> ina_gain_two && pga_gain_select == 2'h0)
      else $error("gain two wrong");
   a_gain_five: assert property (@(posedge mclk) disable iff (!rst_b)
      gain_code == 2'h2
      |=> ina_gain_two && pga_gain_select == 2'h1)
      else $error("gain five wrong");
   a_gain_ten: assert property (@(posedge mclk) disable iff (!rst_b)
      gain_code == 2'h3
      |=> ina_gain_two && pga_gain_select == 2'h2)
      else $error("gain decode wrong");
   // transmit decodes
   a_tx_reset_val: assert property (@(posedge mclk)
      !rst_b
      |=> tx_cfg_reg == 8'h80 && !coupling_cap_short_close)
      else $error("tx reset wrong");
   a_cap_switch: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_tx && !pwdata[7]
      |=> ##1 coupling_cap_short_close)
      else $error("cap switch wrong");
   a_cap_open: assert property (@(posedge mclk) disable iff (!rst_b)
      tx_cfg_reg[7]
      |=> !coupling_cap_short_close)
      else $error("cap switch not open");
   a_restore_sw: assert property (@(posedge mclk) disable iff (!rst_b)
      tx_cfg_reg[6]
      |=> dc_restore_close)
      else $error("restore switch wrong");
   a_restore_open: assert property (@(posedge mclk) disable iff (!rst_b)
      !tx_cfg_reg[6]
      |=> !dc_restore_close)
      else $error("restore switch not open");
   a_drive_reset: assert property (@(posedge mclk) disable iff (!rst_b)
      drv_rst
      |=> drive_amp_reset_close && !synth_dac_enable)
      else $error("drive reset wrong");
   a_drive_normal: assert property (@(posedge mclk) disable iff (!rst_b)
      !drv_rst
      |=> !drive_amp_reset_close && synth_dac_enable)
      else $error("drive not released");
   a_dac_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      dac_rst
      |=> synth_dac_force_zero)
      else $error("dac zero wrong");
   a_dac_normal: assert property (@(posedge mclk) disable iff (!rst_b)
      !dac_rst
      |=> !synth_dac_force_zero)
      else $error("dac held at zero");
   a_drive_decode: assert property (@(posedge mclk) disable iff (!rst_b)
      1'b1
      |=> $onehot(drive_amp_strength) && $onehot(drive_amp_bandwidth))
      else $error("drive decode wrong");
   a_strength_index: assert property (@(posedge mclk) disable iff (!rst_b)
      1'b1
      |=> drive_amp_strength == 4'(4'h1 << $past(tx_cfg_reg[3:2])))
      else $error("strength index wrong");
   a_bw_index: assert property (@(posedge mclk) disable iff (!rst_b)
      1'b1
      |=> drive_amp_bandwidth == 4'(4'h1 << $past(tx_cfg_reg[1:0])))
      else $error("bandwidth index wrong");

   c_ext_res:   cover property (@(posedge mclk) hpf_ext_res_select != 3'h0);
   c_rx_write:  cover property (@(posedge mclk) wr_rx);
   c_tx_write:  cover property (@(posedge mclk) wr_tx);
   c_bad_addr:  cover property (@(posedge mclk) access_phase && !hit_any);
   c_bypass:    cover property (@(posedge mclk) hpf_resistor_open);
endmodule : bzc_config_regs

/* File: rtl/bzc_pkg.sv */
// Purpose: shared constants for the bioimpedance rx/tx configuration bank
// Assumes: apb byte addresses equal to the printed offsets scaled by four
// Notes:   offsets 0x24/0x25 are register indices, not byte addresses
package bzc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0]  RX_CFG_IDX     = 8'h24;
   localparam logic [7:0]  TX_CFG_IDX     = 8'h25;
   localparam logic [11:0] RX_CFG_ADDR    = {2'h0, RX_CFG_IDX, 2'h0};
   localparam logic [11:0] TX_CFG_ADDR    = {2'h0, TX_CFG_IDX, 2'h0};
   localparam logic [7:0]  RX_CFG_RESET   = 8'h00;
   localparam logic [7:0]  TX_CFG_RESET   = 8'h80;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int HPF_LSB      = 4;
   localparam int AMP_MODE_BIT = 3;
   localparam int DEMOD_BIT    = 2;
   localparam int GAIN_LSB     = 0;
   localparam int EXTCAP_BIT   = 7;
   localparam int RESTORE_BIT  = 6;
   localparam int DRVRST_BIT   = 5;
   localparam int DACRST_BIT   = 4;
   localparam int STRENGTH_LSB = 2;
   localparam int BW_LSB       = 0;
   // ----------------------------------------
   // high-pass codes
   // ----------------------------------------
   localparam logic [3:0] HPF_LAST_CORNER = 4'h6;
   localparam logic [3:0] HPF_BYPASS_A    = 4'h7;
   localparam logic [3:0] HPF_BYPASS_B    = 4'hf;
endpackage : bzc_pkg
